/* File: bench/fsi_master_model.sv */
// Purpose: master stand-in; Assumes: called after a rising edge; Notes: idle byte is inverted
`timescale 1ns/1ps
module fsi_master_model (
	input wire CLK,
	output logic IOCS_VALID = 1'h0,
	output logic [7:0] IOCS_BYTE = 8'h00
);
	task send(input logic [7:0] b);
		IOCS_VALID = 1'h1;
		IOCS_BYTE = b;
		@(posedge CLK);
		#1;
		IOCS_VALID = 1'h0;
		IOCS_BYTE = ~b;
	endtask
endmodule

/* File: bench/fsi_top_assertions.sv */
// Purpose: lamp checks; Assumes: blink 4, hold 8; Notes: bound below
`timescale 1ns/1ps
module fsi_top_assertions (
	input wire CLK, RST, POWER_OK, DRIVE_FAULT, MASTER_CONNECTED, IOCS_VALID, PORT_ONE_LINK,
	input wire [7:0] IOCS_BYTE,
	input wire PORT_TWO_LINK, PORT_TWO_RX, PROTOCOL_ENABLE, LINK_SPEED_100, UNIT_HEALTH_LAMP_RED,
	input wire NETWORK_STATE_LAMP_GREEN, PORT_ONE_ACTIVITY_LAMP, PORT_TWO_ACTIVITY_LAMP
);
	wire on = POWER_OK && MASTER_CONNECTED;
	wire up = POWER_OK && PORT_TWO_LINK && !PORT_TWO_RX;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	property p_dark; (!POWER_OK)[*4] |-> !NETWORK_STATE_LAMP_GREEN; endproperty
	a_dark: assert property (p_dark) else $error("dark");
	property p_run; on[*5] ##0 IOCS_VALID && IOCS_BYTE == 8'h80 |-> ##2 NETWORK_STATE_LAMP_GREEN;
	endproperty
	a_run: assert property (p_run) else $error("run");
	property p_blink; (POWER_OK && !MASTER_CONNECTED)[*5] |-> ##[1:9] $changed(NETWORK_STATE_LAMP_GREEN);
	endproperty
	a_blink: assert property (p_blink) else $error("blink");
	property p_red; (POWER_OK && DRIVE_FAULT)[*5] |-> UNIT_HEALTH_LAMP_RED; endproperty
	a_red: assert property (p_red) else $error("red");
	property p_down; (!PORT_ONE_LINK)[*5] |-> !PORT_ONE_ACTIVITY_LAMP; endproperty
	a_down: assert property (p_down) else $error("down");
	property p_idle; up[*8] ##1 up[*6] |-> PORT_TWO_ACTIVITY_LAMP; endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_hold; !$past(RST) |=> $stable(PROTOCOL_ENABLE); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_speed; LINK_SPEED_100; endproperty
	a_speed: assert property (p_speed) else $error("speed");
endmodule
bind fsi_top fsi_top_assertions i_fsi_top_assertions (.*);

/* File: bench/fsi_top_tb.sv */
// Purpose: bench for fsi_top; Assumes: short counts; Notes: reset checks first, then table, then hand tests
`timescale 1ns/1ps
module fsi_top_tb;
	logic CLK = 0, RST = 1, POWER_OK = 1, DRIVE_FAULT = 0, MASTER_CONNECTED = 0;
	logic PORT_ONE_LINK = 0, PORT_ONE_RX = 0, PORT_TWO_LINK = 1, PORT_TWO_RX = 0;
	logic SAFETY_TELEGRAM_CFG = 0;
	logic [1:0] m;
	logic [7:0] SAFETY_COMM_SELECT = 8'h00;
	logic [15:0] PROTOCOL_SELECT_SLOT0 = 16'h8892, PROTOCOL_SELECT_SLOT1 = 16'h0000;
	logic [15:0] PROTOCOL_SELECT_SLOT2 = 16'h0000, PROTOCOL_SELECT_SLOT3 = 16'h0000;
	wire IOCS_VALID, NETWORK_STATE_LAMP_GREEN, UNIT_HEALTH_LAMP_GREEN, UNIT_HEALTH_LAMP_RED;
	wire PORT_ONE_ACTIVITY_LAMP, PORT_TWO_ACTIVITY_LAMP, PROTOCOL_ENABLE, LINK_SPEED_100;
	wire SAFETY_CFG_ERROR;
	wire [7:0] IOCS_BYTE;
	int err_total = 0, comparisons = 0, cyc = 0;
	// connected, fault, byte, port one link and rx, steady network lamp, port one {and, or}
	logic [14:0] rows [5] = '{{2'h2, 8'h80, 2'h2, 1'h1, 2'h3}, {2'h3, 8'h60, 2'h3, 1'h0, 2'h1},
		{2'h0, 8'h80, 2'h0, 1'h0, 2'h0}, {2'h2, 8'h55, 2'h2, 1'h0, 2'h3},
		{2'h2, 8'h80, 2'h3, 1'h1, 2'h1}};
	fsi_top #(.BLINK_CYC(4), .ACT_HOLD_CYC(8)) i_fsi_top (.*);
	fsi_master_model i_fsi_master_model (.*);
	always #5 CLK = ~CLK;
	always @(posedge CLK) if (++cyc > 2000) end_sim;
	task chk(input string s, input logic [1:0] e, input logic [1:0] g);
		comparisons++;
		if (g !== e) $display("FAIL %s exp %b got %b", s, e, g);
		err_total += (g !== e);
	endtask
	task tick(input int k);
		repeat (k) @(posedge CLK);
		#1;
	endtask
	task end_sim;
		err_total += (cyc > 2000);
		$display("checks %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		tick(3);
		chk("rst", 0, {NETWORK_STATE_LAMP_GREEN, UNIT_HEALTH_LAMP_GREEN});
		RST = 0;
		tick(3);
		chk("pn", 1, PROTOCOL_ENABLE);
		chk("speed", 1, LINK_SPEED_100);
		foreach (rows[i]) begin
			{MASTER_CONNECTED, DRIVE_FAULT} = rows[i][14:13];
			{PORT_ONE_LINK, PORT_ONE_RX} = rows[i][4:3];
			tick(12);
			i_fsi_master_model.send(rows[i][12:5]);
			tick(2);
			chk("hg", !rows[i][13], UNIT_HEALTH_LAMP_GREEN);
			chk("hr", rows[i][13], UNIT_HEALTH_LAMP_RED);
			m = {NETWORK_STATE_LAMP_GREEN, PORT_ONE_ACTIVITY_LAMP};
			tick(4);
			chk("ns", rows[i][2], m[1] & NETWORK_STATE_LAMP_GREEN);
			chk("p1", rows[i][1:0], {m[0] & PORT_ONE_ACTIVITY_LAMP, m[0] | PORT_ONE_ACTIVITY_LAMP});
			chk("p2", 1, PORT_TWO_ACTIVITY_LAMP);
		end
		SAFETY_TELEGRAM_CFG = 1;
		PROTOCOL_SELECT_SLOT3 = 16'hb0b6;
		tick(5);
		chk("safe", 1, SAFETY_CFG_ERROR);
		chk("hold", 1, PROTOCOL_ENABLE);
		SAFETY_COMM_SELECT = 8'h01;
		tick(2);
		chk("safe0", 0, SAFETY_CFG_ERROR);
		RST = 1;
		tick(3);
		RST = 0;
		tick(3);
		chk("tsn", 0, PROTOCOL_ENABLE);
		POWER_OK = 0;
		tick(5);
		chk("dark", 0, {UNIT_HEALTH_LAMP_GREEN, UNIT_HEALTH_LAMP_RED});
		end_sim;
	end
endmodule

/* File: rtl/fsi_sync.v */
// Purpose: two-flop synchroniser for a bus of levels
// Assumes: single system clock, synchronous reset
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module fsi_sync #(
	parameter W = 1
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] din,
	output reg [W-1:0] dout
);
	reg [W-1:0] meta_q;
	always @(posedge clk) begin
		if (rst) begin
			meta_q <= {W{1'b0}};
			dout <= {W{1'b0}};
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

/* File: rtl/fsi_top.v */
// Purpose: network, unit-health and port lamps plus protocol selection
// Assumes: lamp inputs from pins are asynchronous; slots sampled at reset release
// Notes: lamp colour pairs are green and red enables, both low means dark
//
// Notes on behaviour
// - network and health lamps dark during reset or power loss
// - network lamp blinks green without connection or with master stopped
// - network lamp steady green only with connection and master running
// - status byte 80h decodes run, 60h decodes stop
// - port lamp dark on link down, steady on link, blinking on receive
// - each port lamp driven from its own port only
// - protocol enabled when code 34962 sits in any selection slot
// - code 45238 in any slot overrides and disables the protocol
// - slot changes take effect only after reset
// - links run at 100 Mbps only, never 10 Mbps
// - safety selection 0 with safety telegram configured reports error
`timescale 1ns/1ps
`include "fsi_consts.vh"
module fsi_top #(
	parameter BLINK_CYC = `FSI_BLINK_CYC,
	parameter ACT_HOLD_CYC = `FSI_ACT_HOLD_CYC
) (
	// clock and reset
	input wire CLK,
	input wire RST,
	// drive state
	input wire POWER_OK,
	input wire DRIVE_FAULT,
	input wire MASTER_CONNECTED,
	input wire IOCS_VALID,
	input wire [7:0] IOCS_BYTE,
	// ports
	input wire PORT_ONE_LINK,
	input wire PORT_ONE_RX,
	input wire PORT_TWO_LINK,
	input wire PORT_TWO_RX,
	// configuration
	input wire [15:0] PROTOCOL_SELECT_SLOT0,
	input wire [15:0] PROTOCOL_SELECT_SLOT1,
	input wire [15:0] PROTOCOL_SELECT_SLOT2,
	input wire [15:0] PROTOCOL_SELECT_SLOT3,
	input wire [7:0] SAFETY_COMM_SELECT,
	input wire SAFETY_TELEGRAM_CFG,
	// lamps
	output reg NETWORK_STATE_LAMP_GREEN,
	output reg UNIT_HEALTH_LAMP_GREEN,
	output reg UNIT_HEALTH_LAMP_RED,
	output reg PORT_ONE_ACTIVITY_LAMP,
	output reg PORT_TWO_ACTIVITY_LAMP,
	// status
	output reg PROTOCOL_ENABLE,
	output reg LINK_SPEED_100,
	output reg SAFETY_CFG_ERROR
);
	wire [7:0] sy;
	localparam NPORT = 2;
	// counts pinned to the counter width so no assignment is silently resized
	localparam [31:0] BLINK_W = BLINK_CYC;
	localparam [31:0] HOLD_W = ACT_HOLD_CYC;
	reg [31:0] blink_cnt_q;
	reg blink_tick_q;
	reg blink_q;
	reg master_run_q;
	reg cfg_taken_q;
	wire [NPORT-1:0] link_s;
	wire [NPORT-1:0] rx_s;
	wire [NPORT-1:0] rx_act;
	reg ns_lamp_d;
	reg health_green_d;
	reg health_red_d;
	reg [NPORT-1:0] port_lamp_d;
	wire pwr = sy[0];
	wire fault = sy[1];
	wire conn = sy[2];
	wire l1 = sy[3];
	wire r1 = sy[4];
	wire l2 = sy[5];
	wire r2 = sy[6];
	wire stgm = sy[7];

	// port-indexed views so each port gets its own copy of the activity logic
	assign link_s = {l2, l1};
	assign rx_s = {r2, r1};

	function is_code;
		input [15:0] s0, s1, s2, s3, code;
		begin
			is_code = (s0 == code) | (s1 == code) | (s2 == code) | (s3 == code);
		end
	endfunction

	fsi_sync #(.W(8)) u_sync (
		.clk(CLK),
		.rst(RST),
		.din({SAFETY_TELEGRAM_CFG, PORT_TWO_RX, PORT_TWO_LINK, PORT_ONE_RX,
			PORT_ONE_LINK, MASTER_CONNECTED, DRIVE_FAULT, POWER_OK}),
		.dout(sy)
	);

	// free-running divider, one-cycle tick every half blink period
	always @(posedge CLK) begin
		if (RST) begin
			blink_cnt_q <= 32'h0;
			blink_tick_q <= 1'b0;
		end else if (blink_cnt_q >= BLINK_W - 32'h1) begin
			blink_cnt_q <= 32'h0;
			blink_tick_q <= 1'b1;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h1;
			blink_tick_q <= 1'b0;
		end
	end

	// blink phase shared by the network and port lamps so they flash in step
	always @(posedge CLK) begin
		if (RST) begin
			blink_q <= 1'b0;
		end else if (blink_tick_q) begin
			blink_q <= ~blink_q;
		end
	end

	// status byte decode, other values keep last state
	always @(posedge CLK) begin
		if (RST | ~conn) begin
			master_run_q <= 1'b0;
		end else if (IOCS_VALID && IOCS_BYTE == `FSI_IOCS_RUN) begin
			master_run_q <= 1'b1;
		end else if (IOCS_VALID && IOCS_BYTE == `FSI_IOCS_STOP) begin
			master_run_q <= 1'b0;
		end
	end

	// receive activity stretched so blinking is visible, one copy per port
	// short frames would otherwise flash for a cycle and never be seen
	genvar gi;
	generate
		for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_port
			reg [31:0] hold_q;
			reg act_q;
			always @(posedge CLK) begin
				if (RST) begin
					hold_q <= 32'h0;
					act_q <= 1'b0;
				end else begin
					act_q <= rx_s[gi] | (hold_q != 32'h0);
					// a new frame restarts the hold window
					if (rx_s[gi]) begin
						hold_q <= HOLD_W;
					end else if (hold_q != 32'h0) begin
						hold_q <= hold_q - 32'h1;
					end
				end
			end
			assign rx_act[gi] = act_q;
		end
	endgenerate

	// configuration captured once after reset release
	always @(posedge CLK) begin
		if (RST) begin
			cfg_taken_q <= 1'b0;
			PROTOCOL_ENABLE <= 1'b0;
		end else if (!cfg_taken_q) begin
			cfg_taken_q <= 1'b1;
			PROTOCOL_ENABLE <= is_code(PROTOCOL_SELECT_SLOT0, PROTOCOL_SELECT_SLOT1,
				PROTOCOL_SELECT_SLOT2, PROTOCOL_SELECT_SLOT3, `FSI_CODE_PN)
				& ~is_code(PROTOCOL_SELECT_SLOT0, PROTOCOL_SELECT_SLOT1,
				PROTOCOL_SELECT_SLOT2, PROTOCOL_SELECT_SLOT3, `FSI_CODE_TSN);
		end
	end

	// next lamp values; power loss forces every lamp dark
	always @* begin
		ns_lamp_d = 1'b0;
		health_green_d = 1'b0;
		health_red_d = 1'b0;
		port_lamp_d = {NPORT{1'b0}};
		if (pwr) begin
			// steady only while connected and running, blinking otherwise
			ns_lamp_d = (conn & master_run_q) ? 1'b1 : blink_q;
			health_green_d = ~fault;
			health_red_d = fault;
			// steady on link, blinking while frames arrive, dark on link down
			port_lamp_d = link_s & (~rx_act | {NPORT{blink_q}});
		end
	end

	// lamps and status outputs, all registered
	always @(posedge CLK) begin
		if (RST) begin
			NETWORK_STATE_LAMP_GREEN <= 1'b0;
			UNIT_HEALTH_LAMP_GREEN <= 1'b0;
			UNIT_HEALTH_LAMP_RED <= 1'b0;
			PORT_ONE_ACTIVITY_LAMP <= 1'b0;
			PORT_TWO_ACTIVITY_LAMP <= 1'b0;
			LINK_SPEED_100 <= `FSI_SPEED_100;
			SAFETY_CFG_ERROR <= 1'b0;
		end else begin
			LINK_SPEED_100 <= `FSI_SPEED_100;
			// level status, clears once the telegram or the selection changes
			SAFETY_CFG_ERROR <= (SAFETY_COMM_SELECT == 8'h00) & stgm;
			NETWORK_STATE_LAMP_GREEN <= ns_lamp_d;
			UNIT_HEALTH_LAMP_GREEN <= health_green_d;
			UNIT_HEALTH_LAMP_RED <= health_red_d;
			PORT_ONE_ACTIVITY_LAMP <= port_lamp_d[0];
			PORT_TWO_ACTIVITY_LAMP <= port_lamp_d[1];
		end
	end
endmodule

/* File: shared/fsi_consts.vh */
// Purpose: constants for the fieldbus status indicator
// Assumes: 100 MHz system clock
// Notes: times in ms, cycle counts derived from them
`ifndef FSI_CONSTS_VH
`define FSI_CONSTS_VH
`define FSI_CLK_HZ 100000000
`define FSI_BLINK_MS 250
`define FSI_BLINK_CYC ((`FSI_CLK_HZ / 1000) * `FSI_BLINK_MS)
`define FSI_ACT_HOLD_MS 50
`define FSI_ACT_HOLD_CYC ((`FSI_CLK_HZ / 1000) * `FSI_ACT_HOLD_MS)
`define FSI_IOCS_RUN 8'h80
`define FSI_IOCS_STOP 8'h60
`define FSI_CODE_PN 16'h8892
`define FSI_CODE_TSN 16'hb0b6
`define FSI_SLOTS 4
`define FSI_SPEED_100 1'b1
`endif
